// ---- saob_alert_builder.sv ----
// Source alert object builder: latches status events, frames one alert
// data object per message and clears what was reported once sent.
// Assumes the transmit layer pulses tx_sent once a handed-over message
// has been delivered, and that all inputs are synchronous to clock.
//
// How it works
// - Present battery shows its charging, discharging or idle code.
// - Absent battery has both charging-status bits forced to zero.
// - Any monitored status change except an over-voltage trip or a trip clearing launches an alert message.
// - Header carries object count one, followed by one alert object.
// - Type byte in bits 31..24; bits 1..5 flag the five events.
// - Type bits 0, 6 and 7 are always zero.
// - Bits 23..20 mark changed fixed batteries, bit 20 is battery 0.
// - Bits 19..16 mark changed hot-swap batteries, bit 16 is battery 0.
// - Each occurrence yields at most one alert, none if flushed, never a repeat.
// - Several pending type bits may share one alert.
// - Type field cleared after the message has been sent.
// - Fixed-battery mask cleared after the message has been sent.
// - Battery flag set on any charging, discharging, idle transition.
// - Hot-swap attach or detach also sets the battery flag.
// - Over-voltage trip sets its own flag; it has no object bit.
// - Over-current trip sets the over-current flag.
// - Over-temperature shutdown sets the over-temperature flag.
// - Entering or leaving orange or red sets operating-condition flag.
// - Any change of supply source sets the input-change flag.
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

module saob_alert_builder
  import saob_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // Battery monitor
  input  wire saob_batt_t [SAOB_NBATT-1:0]  fix_batt,
  input  wire saob_batt_t [SAOB_NBATT-1:0]  hot_batt,
  output logic [2*SAOB_NBATT-1:0]           fix_chg_status,
  output logic [2*SAOB_NBATT-1:0]           hot_chg_status,
  // Protection and condition inputs
  input  wire logic                         overvoltage_trip,
  input  wire logic                         overcurrent_event,
  input  wire logic                         overtemp_shutdown,
  input  wire logic [1:0]                   thermal_state,
  input  wire logic [2:0]                   supply_source,
  // Transmit layer
  output logic                              tx_valid,
  output saob_msg_t                         tx_msg,
  input  wire logic                         tx_ready,
  input  wire logic                         tx_sent
);

  // Sequencer and message
  saob_state_t state_reg;
  saob_state_t state_next;
  saob_msg_t   msg_reg;
  logic [31:0] last_obj_reg;
  logic [15:0] sent_cnt_reg;

  // Pending latches
  logic [7:0]            pend_type_reg;
  logic [SAOB_NBATT-1:0] pend_fix_reg;
  logic [SAOB_NBATT-1:0] pend_hot_reg;
  logic                  ovp_flag_reg;

  // Previous input samples for change detection
  logic                  primed_reg;
  saob_batt_t [SAOB_NBATT-1:0] fix_prev_reg;
  saob_batt_t [SAOB_NBATT-1:0] hot_prev_reg;
  logic                  ovc_prev_reg;
  logic                  otp_prev_reg;
  logic                  ovp_prev_reg;
  logic [1:0]            therm_prev_reg;
  logic [2:0]            src_prev_reg;

  // Control and bus
  logic        enable_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  // Battery i owns bits 2i+1..2i of
  // each status word, as the inputs
  // Per-battery decode
  wire [SAOB_NBATT-1:0]   fix_chg_w;
  wire [SAOB_NBATT-1:0]   hot_chg_w;
  wire [2*SAOB_NBATT-1:0] fix_gate_w;
  wire [2*SAOB_NBATT-1:0] hot_gate_w;
  wire [SAOB_NBATT-1:0]   fix_pres_w;
  wire [SAOB_NBATT-1:0]   hot_pres_w;

  // Fixed: any code move, even absent
  // Hot-swap: attach, detach, or a code
  // move while present
  // Change detection and status gating per battery
  genvar gi;
  generate
    for (gi = 0; gi < SAOB_NBATT; gi++) begin : g_batt
      assign fix_chg_w[gi] = primed_reg &
        (fix_batt[gi].chg != fix_prev_reg[gi].chg);
      assign hot_chg_w[gi] = primed_reg &
        ((hot_batt[gi].present != hot_prev_reg[gi].present) |
         (hot_batt[gi].present &
          (hot_batt[gi].chg != hot_prev_reg[gi].chg)));
      assign fix_gate_w[2*gi +: 2] = fix_batt[gi].present ?
        fix_batt[gi].chg : CHG_NONE;
      assign hot_gate_w[2*gi +: 2] = hot_batt[gi].present ?
        hot_batt[gi].chg : CHG_NONE;
      assign fix_pres_w[gi] = fix_batt[gi].present;
      assign hot_pres_w[gi] = hot_batt[gi].present;
    end
  endgenerate

  // Event decode; nothing fires until the first samples are held
  wire ev_batt = (|fix_chg_w) | (|hot_chg_w);
  wire ev_ovc  = primed_reg & overcurrent_event & ~ovc_prev_reg;
  wire ev_otp  = primed_reg & overtemp_shutdown & ~otp_prev_reg;
  wire ev_ovp  = primed_reg & overvoltage_trip & ~ovp_prev_reg;
  wire ev_src  = primed_reg & (supply_source != src_prev_reg);

  // Trips are levels and only a rise
  // counts, so a held trip is one alert
  // Normal to the unused code 3 is not
  // a condition change
  // Orange or red on either side of a thermal move
  wire th_hot_now  = (thermal_state == TH_ORANGE) |
                     (thermal_state == TH_RED);
  wire th_hot_prev = (therm_prev_reg == TH_ORANGE) |
                     (therm_prev_reg == TH_RED);
  wire ev_opcond   = primed_reg & (thermal_state != therm_prev_reg) &
                     (th_hot_now | th_hot_prev);

  // Assemble the type bits of this cycle's events
  wire [7:0] ev_type_w = ((8'({ev_batt}) << TB_BATT) |
                          (8'({ev_ovc}) << TB_OVRCUR) |
                          (8'({ev_otp}) << TB_OVRTMP) |
                          (8'({ev_opcond}) << TB_OPCOND) |
                          (8'({ev_src}) << TB_INPUT)) &
                         TYPE_MASK;

  // Register map, byte offsets
  //   CTRL   bit 0 enable, reset one
  //          bit 1 flush, reads zero
  //   STATUS pending type and masks,
  //          over-voltage, busy
  //   OBJECT last delivered object
  //   BATT   gated status, presence
  //   COUNT  messages, wraps at 16 bits
  // Unmapped reads give zero
  // Writes to read-only words drop,
  // apart from the over-voltage clear
  // Bus decode; one wait state on every access
  wire bus_req  = avs_read | avs_write;
  wire bus_fire = bus_req & ack_reg;
  wire wr_fire  = avs_write & ack_reg;
  wire sel_ctrl = (avs_address == REG_CTRL);
  wire sel_stat = (avs_address == REG_STATUS);
  wire wr_ctrl  = wr_fire & sel_ctrl & avs_byteenable[0];
  wire flush_w  = wr_ctrl & avs_writedata[CTRL_FLUSH];
  wire ovp_clr  = wr_fire & sel_stat & avs_byteenable[2] &
                  avs_writedata[ST_OVP];

  // Launch when idle, enabled and something is pending
  wire st_idle   = (state_reg == ST_IDLE);
  wire capture_w = st_idle & enable_reg & (|pend_type_reg);
  wire sent_w    = (state_reg == ST_WAIT) & tx_sent;

  // Pending latches drop their content at launch or flush, so each occurrence
  // reaches at most one message; new events always win over the clear
  wire       pend_drop = capture_w | flush_w;
  wire [7:0] pend_type_next =
    ((pend_drop ? 8'h00 : pend_type_reg) | ev_type_w) &
    TYPE_MASK;
  wire [SAOB_NBATT-1:0] pend_fix_next =
    (pend_drop ? '0 : pend_fix_reg) | fix_chg_w;
  wire [SAOB_NBATT-1:0] pend_hot_next =
    (pend_drop ? '0 : pend_hot_reg) | hot_chg_w;

  // Snapshot comes from the latches, so
  // an event of the launch cycle itself
  // waits for the following alert
  // Object built from the pending snapshot; low half stays zero
  wire [31:0] obj_build =
    (32'(pend_type_reg & TYPE_MASK) << TYPE_LSB) |
    (32'(pend_fix_reg) << FIXED_LSB) |
    (32'(pend_hot_reg) << HOT_LSB);

  // No object bit exists for it, so it
  // is kept for software only
  // Sticky over-voltage flag, set wins over a software clear
  wire ovp_flag_next = ev_ovp | (ovp_flag_reg & ~ovp_clr);

  // Idle timing: an event sampled at
  // one edge is pending after it, the
  // launch is taken at the next edge
  // and the offer follows. The offer
  // holds until tx_ready, the message
  // until tx_sent, so the link may
  // read it at any time in between.
  // Stray tx_sent pulses are ignored.
  // Next state of the transmit sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (capture_w) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_ready) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tx_sent) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Count field loads at each launch and stays;
  // delivery clears only the object
  // Message register; count field fixed, object cleared once sent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      msg_reg <= '0;
    end else if (capture_w) begin
      msg_reg.obj_count <= OBJ_COUNT;
      msg_reg.object    <= obj_build;
    end else if (sent_w) begin
      msg_reg.object <= '0;
    end
  end

  // Copy of the last delivered object and a delivery count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_obj_reg <= '0;
      sent_cnt_reg <= '0;
    end else if (sent_w) begin
      last_obj_reg <= msg_reg.object;
      sent_cnt_reg <= sent_cnt_reg + 16'h0001;
    end
  end

  // Pending latches and over-voltage flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_type_reg <= '0;
      pend_fix_reg  <= '0;
      pend_hot_reg  <= '0;
      ovp_flag_reg  <= 1'b0;
    end else begin
      pend_type_reg <= pend_type_next;
      pend_fix_reg  <= pend_fix_next;
      pend_hot_reg  <= pend_hot_next;
      ovp_flag_reg  <= ovp_flag_next;
    end
  end

  // Input history; reset cannot load ports, so the first clocked
  // cycle after release takes the samples and arms detection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
    end
  end

  // No reset: reloaded every edge, and
  // primed_reg masks the first compare
  // Sampled copies used by the edge and change detectors
  always_ff @(posedge clock) begin
    fix_prev_reg   <= fix_batt;
    hot_prev_reg   <= hot_batt;
    ovc_prev_reg   <= overcurrent_event;
    otp_prev_reg   <= overtemp_shutdown;
    ovp_prev_reg   <= overvoltage_trip;
    therm_prev_reg <= thermal_state;
    src_prev_reg   <= supply_source;
  end

  // Registered charging status toward the battery report
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fix_chg_status <= '0;
      hot_chg_status <= '0;
    end else begin
      fix_chg_status <= fix_gate_w;
      hot_chg_status <= hot_gate_w;
    end
  end

  // Disabling lets software gather
  // events into one alert; a flush
  // drops what it does not want sent
  // Enable bit; while clear, events pile up and nothing is sent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable_reg <= CTRL_EN_RST;
    end else if (wr_ctrl) begin
      enable_reg <= avs_writedata[CTRL_EN];
    end
  end

  // Read data views
  wire [31:0] rd_ctrl = 32'({enable_reg}) << CTRL_EN;
  wire [31:0] rd_stat = 32'(pend_type_reg) |
                        (32'(pend_fix_reg) << ST_FIX_LSB) |
                        (32'(pend_hot_reg) << ST_HOT_LSB) |
                        (32'({ovp_flag_reg}) << ST_OVP) |
                        (32'({~st_idle}) << ST_BUSY);
  wire [31:0] rd_batt = {8'h00, hot_pres_w, fix_pres_w,
                         hot_chg_status, fix_chg_status};
  wire [31:0] rd_mux =
    (avs_address == REG_CTRL)   ? rd_ctrl :
    (avs_address == REG_STATUS) ? rd_stat :
    (avs_address == REG_OBJECT) ? last_obj_reg :
    (avs_address == REG_BATT)   ? rd_batt :
    (avs_address == REG_COUNT)  ? {16'h0000, sent_cnt_reg} :
    32'h0000_0000;

  // Two cycles per access, back to back
  // too; the slave never stalls longer
  // so no bus timeout is needed here
  // Bus acknowledge and read data; data is ready with the ack so it
  // stands at the edge where waitrequest is low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // tx_valid comes from the state and
  // drops the cycle after acceptance
  // Ports
  assign avs_waitrequest = bus_req & ~bus_fire;
  assign avs_readdata    = rdata_reg;
  assign tx_valid        = (state_reg == ST_SEND);
  assign tx_msg          = msg_reg;

endmodule

// ---- saob_pkg.sv ----
// Constants, layouts and carriers for the source alert object builder.
// Assumes one protocol clock; the message layer outside owns framing.
package saob_pkg;

  // Batteries per group, fixed and hot-swappable
  localparam int SAOB_NBATT = 4;

  // Field positions inside the 32-bit alert data object
  localparam int TYPE_LSB  = 24;
  localparam int FIXED_LSB = 20;
  localparam int HOT_LSB   = 16;

  // Bit positions inside the alert-type byte
  localparam int TB_BATT   = 1;
  localparam int TB_OVRCUR = 2;
  localparam int TB_OVRTMP = 3;
  localparam int TB_OPCOND = 4;
  localparam int TB_INPUT  = 5;

  // Bits 0, 7 and 6 of the type byte are always zero
  localparam logic [7:0] TYPE_MASK = 8'h3e;

  // Data-object count carried by every alert header
  localparam logic [2:0] OBJ_COUNT = 3'h1;

  // Charging status codes and the forced value when absent
  localparam logic [1:0] CHG_CHARGING = 2'h0;
  localparam logic [1:0] CHG_DISCHRG  = 2'h1;
  localparam logic [1:0] CHG_IDLE     = 2'h2;
  localparam logic [1:0] CHG_NONE     = 2'h0;

  // Thermal condition codes
  localparam logic [1:0] TH_NORMAL = 2'h0;
  localparam logic [1:0] TH_ORANGE = 2'h1;
  localparam logic [1:0] TH_RED    = 2'h2;

  // Register byte offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_OBJECT = 5'h08;
  localparam logic [4:0] REG_BATT   = 5'h0c;
  localparam logic [4:0] REG_COUNT  = 5'h10;

  // Control and status bit positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_FLUSH = 1;
  localparam int ST_FIX_LSB = 8;
  localparam int ST_HOT_LSB = 12;
  localparam int ST_OVP     = 16;
  localparam int ST_BUSY    = 17;
  localparam logic CTRL_EN_RST = 1'b1;

  // One battery as reported by the battery monitor
  typedef struct packed {
    logic       present;
    logic [1:0] chg;
  } saob_batt_t;

  // Message handed to the transmit layer
  typedef struct packed {
    logic [2:0]  obj_count;
    logic [31:0] object;
  } saob_msg_t;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } saob_state_t;

endpackage

// ---- saob_alert_builder_checker.sv ----
// Port assertions for the source alert object builder.
// Assumes a bind from the bench and one clock domain.
`timescale 1ns/1ps
module saob_alert_builder_checker
  import saob_pkg::*;
(
  input wire logic                        clock,
  input wire logic                        sys_rst,
  input wire saob_batt_t [SAOB_NBATT-1:0] fix_batt,
  input wire saob_batt_t [SAOB_NBATT-1:0] hot_batt,
  input wire logic [2*SAOB_NBATT-1:0]     fix_chg_status,
  input wire logic [2*SAOB_NBATT-1:0]     hot_chg_status,
  input wire logic                        overcurrent_event,
  input wire logic                        overtemp_shutdown,
  input wire logic [1:0]                  thermal_state,
  input wire logic [2:0]                  supply_source,
  input wire logic                        tx_valid,
  input wire saob_msg_t                   tx_msg,
  input wire logic                        tx_ready,
  input wire logic                        tx_sent
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Absent batteries read as zero
  function automatic logic [2*SAOB_NBATT-1:0] chg_of(
    input saob_batt_t [SAOB_NBATT-1:0] b);
    logic [2*SAOB_NBATT-1:0] r;
    for (int i = 0; i < SAOB_NBATT; i++) begin
      r[2*i+:2] = b[i].present ? b[i].chg : CHG_NONE;
    end
    return r;
  endfunction

  // Expected status and the type byte on the link
  wire logic [4*SAOB_NBATT-1:0] chg_exp   =
    {chg_of(hot_batt), chg_of(fix_batt)};
  wire logic [7:0]              type_byte = tx_msg.object[31:24];

  // Handoff, then the link must rest before another offer
  sequence s_handoff;
    tx_valid && tx_ready;
  endsequence
  sequence s_rest;
    !tx_valid [*2];
  endsequence

  a_chg_follow: assert property (
    !$past(sys_rst) |-> {hot_chg_status, fix_chg_status} == $past(chg_exp))
    else $error("charging status mismatch");
  a_count_one: assert property (
    tx_valid |-> tx_msg.obj_count == OBJ_COUNT)
    else $error("object count not one");
  a_type_reserved: assert property (
    tx_valid |-> (type_byte & ~TYPE_MASK) == 8'h00)
    else $error("reserved type bits set");
  a_low_zero: assert property (
    tx_valid |-> tx_msg.object[15:0] == 16'h0000)
    else $error("low object half not zero");
  a_mask_battery: assert property (
    tx_valid && tx_msg.object[23:16] != 8'h00 |-> type_byte[TB_BATT])
    else $error("battery mask without battery flag");
  a_single_alert: assert property (
    s_handoff |=> s_rest)
    else $error("alert offered again too soon");
  a_clear_sent: assert property (
    tx_sent |=> tx_msg.object == 32'h0000_0000)
    else $error("object not cleared after delivery");
  a_overcur_alert: assert property (
    $rose(overcurrent_event) |-> ##[1:40] tx_valid && type_byte[TB_OVRCUR])
    else $error("over-current alert missing");
  a_overtemp_alert: assert property (
    $rose(overtemp_shutdown) |-> ##[1:40] tx_valid && type_byte[TB_OVRTMP])
    else $error("over-temperature alert missing");
  a_opcond_alert: assert property (
    $changed(thermal_state) |-> ##[1:40] tx_valid && type_byte[TB_OPCOND])
    else $error("condition alert missing");
  a_input_alert: assert property (
    $changed(supply_source) |-> ##[1:40] tx_valid && type_byte[TB_INPUT])
    else $error("input change alert missing");
endmodule

// ---- saob_sink_model.sv ----
// Far side: transmit layer and the sink's policy engine.
// Assumes tx_valid holds until accepted; slow stretches both waits.
`timescale 1ns/1ps
module saob_sink_model
  import saob_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      sys_rst,
  input  wire logic      slow,
  input  wire logic      tx_valid,
  input  wire saob_msg_t tx_msg,
  output logic           tx_ready,
  output logic           tx_sent,
  output logic           req_batt,
  output logic           req_src
);
  logic [1:0]      phase_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      type_reg;
  wire logic [3:0] delay = slow ? 4'h6 : 4'h0;

  // Accept, deliver, then ask for the details of the alert
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_reg <= 2'h0;
      cnt_reg <= 4'h0;
      type_reg <= 8'h00;
      tx_ready <= 1'b0;
      tx_sent <= 1'b0;
      req_batt <= 1'b0;
      req_src <= 1'b0;
    end else begin
      tx_sent <= 1'b0;
      req_batt <= 1'b0;
      req_src <= 1'b0;
      cnt_reg <= cnt_reg + 4'h1;
      case (phase_reg)
        2'h0: begin
          if (!tx_valid) begin
            cnt_reg <= 4'h0;
          end else if (cnt_reg >= delay) begin
            tx_ready <= 1'b1;
            phase_reg <= 2'h1;
          end
        end
        2'h1: begin
          if (tx_valid && tx_ready) begin
            tx_ready <= 1'b0;
            type_reg <= tx_msg.object[31:24];
            cnt_reg <= 4'h0;
            phase_reg <= 2'h2;
          end
        end
        default: begin
          if (cnt_reg >= delay) begin
            tx_sent <= 1'b1;
            req_batt <= type_reg[TB_BATT];
            req_src <= |type_reg[TB_INPUT:TB_OVRCUR];
            phase_reg <= 2'h0;
          end
        end
      endcase
    end
  end
endmodule

// ---- saob_alert_builder_bench.sv ----
// Self-checking bench for the source alert object builder.
// Assumes the sink model on the link and the checker bound below.
`timescale 1ns/1ps
module saob_alert_builder_bench
  import saob_pkg::*;
;
  logic                        clock, sys_rst, avs_read, avs_write;
  logic [4:0]                  avs_address;
  logic [31:0]                 avs_writedata, avs_readdata, rd;
  logic [3:0]                  avs_byteenable;
  logic                        avs_waitrequest, slow, tx_valid;
  saob_batt_t [SAOB_NBATT-1:0] fix_batt, hot_batt;
  logic [2*SAOB_NBATT-1:0]     fix_chg_status, hot_chg_status;
  logic                        overvoltage_trip, overcurrent_event;
  logic                        overtemp_shutdown, tx_ready, tx_sent;
  logic [1:0]                  thermal_state;
  logic [2:0]                  supply_source;
  saob_msg_t                   tx_msg;
  int                          errors, comparisons, cycles;

  saob_alert_builder saob_alert_builder_inst (.clock, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .fix_batt, .hot_batt, .fix_chg_status,
    .hot_chg_status, .overvoltage_trip, .overcurrent_event,
    .overtemp_shutdown, .thermal_state, .supply_source, .tx_valid, .tx_msg,
    .tx_ready, .tx_sent);
  saob_sink_model saob_sink_model_inst (.clock, .sys_rst, .slow, .tx_valid,
    .tx_msg, .tx_ready, .tx_sent, .req_batt(), .req_src());

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] obj_of(input logic [7:0] t,
                                         input logic [3:0] f, h);
    return {t, f, h, 16'h0000};
  endfunction

  // Bus cycles hold the request until waitrequest is seen low
  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d,
                           input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Waits for one offered alert, judges it, then lets it go
  task automatic wait_msg(input logic [31:0] exp);
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("tx_valid", {31'h0, tx_valid}, 32'h0000_0001);
    check("count", {29'h0, tx_msg.obj_count}, {29'h0, OBJ_COUNT});
    check("object", tx_msg.object, exp);
    while (tx_valid === 1'b1) begin
      @(posedge clock);
      #1;
    end
  endtask

  // No further offer for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (tx_valid !== 1'b0) seen = 1'b1;
    end
    check("repeat", {31'h0, seen}, 32'h0000_0000);
  endtask

  task automatic t_reset();
    check("chg_rst", {16'h0, hot_chg_status, fix_chg_status}, 32'h0);
    bus_read(REG_CTRL, rd);
    check("ctrl", rd, 32'h0000_0001);
    bus_read(5'h14, rd);
    check("unmapped", rd, 32'h0000_0000);
  endtask

  task automatic t_battery();
    @(posedge clock);
    fix_batt[2] <= {1'b1, CHG_DISCHRG};
    wait_msg(obj_of(8'h01 << TB_BATT, 4'h4, 4'h0));
    check("fix_chg", {24'h0, fix_chg_status}, 32'h0000_0010);
    @(posedge clock);
    hot_batt[3] <= {1'b1, CHG_IDLE};
    hot_batt[1] <= {1'b0, CHG_DISCHRG};
    wait_msg(obj_of(8'h01 << TB_BATT, 4'h0, 4'h8));
    check("hot_chg", {24'h0, hot_chg_status}, 32'h0000_0080);
    quiet(20);
  endtask

  task automatic t_events();
    int kinds [4];
    kinds = '{TB_OVRCUR, TB_OVRTMP, TB_OPCOND, TB_INPUT};
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      case (k)
        0: overcurrent_event <= 1'b1;
        1: {overcurrent_event, overtemp_shutdown} <= 2'h1;
        2: {overtemp_shutdown, thermal_state} <= {1'b0, TH_ORANGE};
        default: supply_source <= 3'h1;
      endcase
      wait_msg(obj_of(8'h01 << kinds[k], 4'h0, 4'h0));
      quiet(20);
    end
  endtask

  task automatic t_merge();
    @(posedge clock);
    overcurrent_event <= 1'b1;
    supply_source <= 3'h2;
    wait_msg(obj_of(8'h24, 4'h0, 4'h0));
    @(posedge clock);
    overcurrent_event <= 1'b0;
    quiet(20);
  endtask

  // Second event lands while the first alert is still in flight
  task automatic t_pending();
    @(posedge clock);
    slow <= 1'b1;
    overtemp_shutdown <= 1'b1;
    wait_msg(obj_of(8'h01 << TB_OVRTMP, 4'h0, 4'h0));
    @(posedge clock);
    thermal_state <= TH_RED;
    wait_msg(obj_of(8'h01 << TB_OPCOND, 4'h0, 4'h0));
    @(posedge clock);
    slow <= 1'b0;
    overtemp_shutdown <= 1'b0;
    quiet(30);
  endtask

  task automatic t_ovp();
    @(posedge clock);
    overvoltage_trip <= 1'b1;
    quiet(20);
    bus_read(REG_STATUS, rd);
    check("ovp", rd & 32'h0001_0000, 32'h0001_0000);
    bus_write(REG_STATUS, 32'h0001_0000, 4'h4);
    bus_read(REG_STATUS, rd);
    check("ovp_clr", rd & 32'h0001_0000, 32'h0000_0000);
  endtask

  // Enable, flush and the read-only views
  task automatic t_regs();
    bus_write(REG_CTRL, 32'h0000_0000, 4'h1);
    @(posedge clock);
    fix_batt[0] <= {1'b0, CHG_IDLE};
    quiet(20);
    bus_read(REG_STATUS, rd);
    check("held", rd, 32'h0000_0102);
    bus_read(REG_BATT, rd);
    check("batt", rd, 32'h0084_8010);
    bus_write(REG_CTRL, 32'h0000_0002, 4'h1);
    bus_read(REG_STATUS, rd);
    check("flushed", rd, 32'h0000_0000);
    bus_write(REG_CTRL, 32'h0000_0001, 4'h1);
    quiet(20);
    bus_read(REG_COUNT, rd);
    check("sent_count", rd, 32'h0000_0009);
    bus_read(REG_OBJECT, rd);
    check("last_obj", rd, obj_of(8'h01 << TB_OPCOND, 4'h0, 4'h0));
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      summarize();
    end
  end

  initial begin
    {errors, comparisons, cycles} = '0;
    {sys_rst, avs_read, avs_write, slow} = 4'h8;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {fix_batt, hot_batt} = '0;
    {overvoltage_trip, overcurrent_event, overtemp_shutdown} = 3'h0;
    thermal_state = TH_NORMAL;
    supply_source = 3'h0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    t_reset();
    t_battery();
    t_events();
    t_merge();
    t_pending();
    t_ovp();
    t_regs();
    summarize();
  end
endmodule

bind saob_alert_builder saob_alert_builder_checker
  saob_alert_builder_checker_inst (.clock, .sys_rst, .fix_batt, .hot_batt,
  .fix_chg_status, .hot_chg_status, .overcurrent_event, .overtemp_shutdown,
  .thermal_state, .supply_source, .tx_valid, .tx_msg, .tx_ready, .tx_sent);
